/* File: hdl/item_buffer.sv */
`timescale 1ns/1ps
module item_buffer
    import dma_pkg::*;
(
    // Clock, reset and clock enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Data path
    buf_if.buffer port
);
    logic [DATA_W-1:0] mem [BUF_DEPTH];
    logic [DATA_W-1:0] next_mem [BUF_DEPTH];
    logic wp;
    logic rp;
    logic [1:0] cnt;
    logic next_wp;
    logic next_rp;
    logic [1:0] next_cnt;
    logic push;
    logic pop;

    assign port.in_ready = (cnt != BUF_FULL);
    assign port.out_valid = (cnt != BUF_EMPTY);
    assign port.out_data = mem[rp];

    always_comb begin
        push = port.in_valid & port.in_ready;
        pop = port.out_valid & port.out_ready;
        next_mem = mem;
        next_wp = wp;
        next_rp = rp;
        next_cnt = cnt;
        if (push) begin
            next_mem[wp] = port.in_data;
            next_wp = ~wp;
        end
        if (pop) begin
            next_rp = ~rp;
        end
        if (push & ~pop) begin
            next_cnt = cnt + 2'h1;
        end else if (pop & ~push) begin
            next_cnt = cnt - 2'h1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem <= '{default: DATA_RESET};
            wp <= 1'b0;
            rp <= 1'b0;
            cnt <= BUF_EMPTY;
        end else if (ce_i) begin
            mem <= next_mem;
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
        end
    end
endmodule : item_buffer

/* File: hdl/transfer_controller.sv */
`timescale 1ns/1ps
module transfer_controller
    import dma_pkg::*;
(
    // Clock, reset, clock enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Channel control, one bit or field per channel
    input wire logic [CH_N-1:0] chan_enable_i,
    input wire logic [CH_N-1:0] dir_i,
    input wire logic [CH_N-1:0] indirect_i,
    input wire logic [CH_N-1:0] continuous_i,
    input wire logic [CH_N-1:0] size16_i,
    input wire logic [CH_N-1:0][1:0] a_step_i,
    input wire logic [CH_N-1:0][1:0] b_step_i,
    input wire logic [CH_N-1:0] a_adjust_i,
    input wire logic [CH_N-1:0] b_adjust_i,
    input wire logic [CH_N-1:0] tc_int_en_i,
    input wire logic [CH_N-1:0] ovr_int_en_i,
    // Counter load
    input wire logic [CH_N-1:0] load_i,
    input wire logic [ADDR_W-1:0] load_addr_a_i,
    input wire logic [ADDR_W-1:0] load_addr_b_i,
    input wire logic [LEN_W-1:0] load_len_i,
    // Flag clears, write-one style
    input wire logic [CH_N-1:0] tc_clear_i,
    input wire logic [CH_N-1:0] ovr_clear_i,
    // Transfer requests
    input wire logic [CH_N-1:0] periph_req_i,
    input wire logic [CH_N-1:0] sw_req_i,
    // CPU bus
    input wire logic bus_gnt_i,
    input wire logic bus_rdy_i,
    input wire logic [DATA_W-1:0] bus_rdata_i,
    output logic bus_req_o,
    output logic [ADDR_W-1:0] bus_addr_o,
    output logic bus_rd_o,
    output logic bus_wr_o,
    output logic bus_size16_o,
    output logic [DATA_W-1:0] bus_wdata_o,
    output logic [CH_N-1:0] ack_o,
    // Channel status
    output logic [CH_N-1:0] tc_o,
    output logic [CH_N-1:0] ovr_o,
    output logic [CH_N-1:0] active_o,
    output logic [CH_N-1:0] irq_o
);
    //------------------------------------------------------------------
    // Shared state
    //------------------------------------------------------------------
    logic [ADDR_W-1:0] addr_a [CH_N];
    logic [ADDR_W-1:0] addr_b [CH_N];
    logic [LEN_W-1:0] len [CH_N];
    logic [CH_N-1:0] req_raw;
    logic [CH_N-1:0] pending;
    logic [1:0] win;
    logic any_pending;
    state_t state;
    state_t next_state;
    logic [1:0] cur;
    logic [1:0] next_cur;
    logic next_req;
    logic [ADDR_W-1:0] next_addr;
    logic next_rd;
    logic next_wr;
    logic next_size16;
    logic [CH_N-1:0] next_ack;
    logic item_done;
    logic launch;
    logic [1:0] launch_ch;
    logic [ADDR_W-1:0] launch_a;
    logic [ADDR_W-1:0] launch_b;

    buf_if temp ();

    item_buffer u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .port(temp.buffer)
    );

    function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
                                                    input logic [1:0] code);
        case (code)
            STEP_INC1: step_addr = a + ADDR_ONE;
            STEP_INC2: step_addr = a + ADDR_TWO;
            STEP_DEC1: step_addr = a - ADDR_ONE;
            default: step_addr = a - ADDR_TWO;
        endcase
    endfunction : step_addr

    //------------------------------------------------------------------
    // Per-channel counters and flags
    //------------------------------------------------------------------
    generate
        for (genvar g = 0; g < CH_N; g++) begin : g_chan
            logic en_q;
            logic next_en_q;
            logic [ADDR_W-1:0] next_a;
            logic [ADDR_W-1:0] next_b;
            logic [LEN_W-1:0] next_len;
            logic next_tc;
            logic next_ovr;
            logic next_active;
            logic next_irq;
            logic done_here;
            logic end_here;

            always_comb begin
                done_here = item_done & (cur == 2'(g));
                end_here = done_here & (len[g] == LEN_ONE);
                next_en_q = chan_enable_i[g];
                next_a = addr_a[g];
                next_b = addr_b[g];
                next_len = len[g];
                next_active = active_o[g];
                if (load_i[g] & ~active_o[g]) begin
                    next_a = load_addr_a_i;
                    next_b = load_addr_b_i;
                    next_len = load_len_i;
                end
                if (chan_enable_i[g] & ~en_q & (len[g] != LEN_ZERO)) begin
                    next_active = 1'b1;
                end
                if (~chan_enable_i[g]) begin
                    next_active = 1'b0;
                end
                if (done_here) begin
                    next_len = len[g] - LEN_ONE;
                    if (a_adjust_i[g]) begin
                        next_a = step_addr(addr_a[g], a_step_i[g]);
                    end
                    if (indirect_i[g] & b_adjust_i[g]) begin
                        next_b = step_addr(addr_b[g], b_step_i[g]);
                    end
                end
                if (end_here) begin
                    next_active = 1'b0;
                end
                next_tc = (tc_o[g] & ~tc_clear_i[g]) | end_here;
                next_ovr = (ovr_o[g] & ~ovr_clear_i[g]) | end_here;
                next_irq = (next_tc & tc_int_en_i[g]) | (next_ovr & ovr_int_en_i[g]);
            end

            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    en_q <= 1'b0;
                    addr_a[g] <= ADDR_RESET;
                    addr_b[g] <= ADDR_RESET;
                    len[g] <= LEN_ZERO;
                    tc_o[g] <= 1'b0;
                    ovr_o[g] <= 1'b0;
                    active_o[g] <= 1'b0;
                    irq_o[g] <= 1'b0;
                end else if (ce_i) begin
                    en_q <= next_en_q;
                    addr_a[g] <= next_a;
                    addr_b[g] <= next_b;
                    len[g] <= next_len;
                    tc_o[g] <= next_tc;
                    ovr_o[g] <= next_ovr;
                    active_o[g] <= next_active;
                    irq_o[g] <= next_irq;
                end
            end
        end
    endgenerate

    //------------------------------------------------------------------
    // Request qualification and priority
    //------------------------------------------------------------------
    always_comb begin
        req_raw = periph_req_i | sw_req_i;
        pending = req_raw & chan_enable_i & active_o;
        any_pending = |pending;
        win = 2'h0;
        for (int i = CH_N - 1; i >= 0; i--) begin
            if (pending[i]) begin
                win = 2'(i);
            end
        end
    end

    //------------------------------------------------------------------
    // Bus sequencer
    //------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cur = cur;
        next_req = bus_req_o;
        next_addr = bus_addr_o;
        next_rd = bus_rd_o;
        next_wr = bus_wr_o;
        next_size16 = bus_size16_o;
        next_ack = ack_o;
        item_done = 1'b0;
        launch = 1'b0;
        launch_ch = cur;
        temp.in_valid = 1'b0;
        temp.in_data = size16_i[cur] ? bus_rdata_i : (bus_rdata_i & BYTE_MASK);
        temp.out_ready = 1'b0;
        case (state)
            S_IDLE: begin
                if (any_pending) begin
                    next_state = S_ARB;
                    next_req = 1'b1;
                end
            end
            S_ARB: begin
                if (bus_gnt_i) begin
                    next_state = S_PRIO;
                end
            end
            S_PRIO: begin
                if (any_pending) begin
                    launch = 1'b1;
                    launch_ch = win;
                end else begin
                    next_state = S_IDLE;
                    next_req = 1'b0;
                end
            end
            S_CYC: begin
                if (bus_rdy_i) begin
                    next_rd = 1'b0;
                    next_wr = 1'b0;
                    next_ack = ACK_NONE;
                    if (indirect_i[cur]) begin
                        temp.in_valid = 1'b1;
                        next_state = S_WR;
                        next_addr = dir_i[cur] ? addr_a[cur] : addr_b[cur];
                    end else begin
                        item_done = 1'b1;
                    end
                end
            end
            S_WR: begin
                if (bus_wr_o & bus_rdy_i) begin
                    temp.out_ready = 1'b1;
                    item_done = 1'b1;
                    next_wr = 1'b0;
                    next_ack = ACK_NONE;
                end else if (temp.out_valid) begin
                    next_wr = 1'b1;
                    next_ack = ACK_ONE << cur;
                end
            end
            default: begin
                next_state = S_IDLE;
                next_req = 1'b0;
            end
        endcase
        if (item_done) begin
            if (continuous_i[cur] & req_raw[cur] & chan_enable_i[cur]
                & (len[cur] != LEN_ONE)) begin
                launch = 1'b1;
                launch_ch = cur;
            end else begin
                next_state = S_IDLE;
                next_req = 1'b0;
            end
        end
        launch_a = addr_a[launch_ch];
        launch_b = addr_b[launch_ch];
        if (item_done) begin
            // Back-to-back item uses the counters as they step this edge
            if (a_adjust_i[cur]) begin
                launch_a = step_addr(addr_a[cur], a_step_i[cur]);
            end
            if (indirect_i[cur] & b_adjust_i[cur]) begin
                launch_b = step_addr(addr_b[cur], b_step_i[cur]);
            end
        end
        if (launch) begin
            next_state = S_CYC;
            next_cur = launch_ch;
            next_size16 = size16_i[launch_ch];
            next_addr = (indirect_i[launch_ch] & dir_i[launch_ch]) ?
                launch_b : launch_a;
            next_rd = indirect_i[launch_ch] | ~dir_i[launch_ch];
            next_wr = ~indirect_i[launch_ch] & dir_i[launch_ch];
            next_ack = indirect_i[launch_ch] ? ACK_NONE : (ACK_ONE << launch_ch);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= S_IDLE;
            cur <= 2'h0;
            bus_req_o <= 1'b0;
            bus_addr_o <= ADDR_RESET;
            bus_rd_o <= 1'b0;
            bus_wr_o <= 1'b0;
            bus_size16_o <= 1'b0;
            bus_wdata_o <= DATA_RESET;
            ack_o <= ACK_NONE;
        end else if (ce_i) begin
            state <= next_state;
            cur <= next_cur;
            bus_req_o <= next_req;
            bus_addr_o <= next_addr;
            bus_rd_o <= next_rd;
            bus_wr_o <= next_wr;
            bus_size16_o <= next_size16;
            bus_wdata_o <= temp.out_data;
            ack_o <= next_ack;
        end
    end
endmodule : transfer_controller

/* File: include/buf_if.sv */
`timescale 1ns/1ps
interface buf_if;
    import dma_pkg::*;
    logic in_valid;
    logic in_ready;
    logic [DATA_W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [DATA_W-1:0] out_data;
    modport buffer (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : buf_if

/* File: include/dma_pkg.sv */
//------------------------------------------------------------------
// Functional notes
// - Requests come only from on-chip peripheral lines or software request bits.
// - A request on an enabled channel first wins the CPU bus, then transfers.
// - Fixed priority, channel 0 highest, resolved one cycle before the transfer.
// - Acknowledge the requester during the bus cycle that accesses it.
// - At block end update flags, raise interrupt if enabled, then release bus (here flags, interrupt and bus release all change on the same edge).
// - Continuous policy with request still high and block unfinished keeps transferring.
// - Next request sampled as acknowledge drops, then on every rising edge.
// - Four identical channels, 0 to 3, each with its own control state.
// - Direct mode moves an item in one bus cycle, never latched.
// - Intermittent hands back the bus per cycle; continuous keeps it until done.
// - Direct throughput at most one per three clocks intermittent, one per clock continuous.
// - Direct uses A counter; direction clear reads addressed device, set writes it.
// - Size select chooses 8 or 16 bits per transfer cycle in both modes.
// - Each item decrements block length by one; direct steps the A counter.
// - Indirect reads into a temporary store, writes it out next cycle (here the write cycle starts one idle clock after the read completes).
// - Indirect throughput at most one per five clocks intermittent, one per two continuous.
// - Indirect direction 0 reads via A writes via B; set reads B writes A.
// - Indirect steps both A and B counters by their own step and adjust settings.
// - Length reaching zero stops, sets terminal and overrun, clears active, interrupts.
//------------------------------------------------------------------
package dma_pkg;
    localparam int CH_N = 4;
    localparam int ADDR_W = 24;
    localparam int LEN_W = 16;
    localparam int DATA_W = 16;
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] BUF_FULL = 2'h2;
    localparam logic [1:0] BUF_EMPTY = 2'h0;
    localparam logic [1:0] STEP_INC1 = 2'h0;
    localparam logic [1:0] STEP_INC2 = 2'h1;
    localparam logic [1:0] STEP_DEC1 = 2'h2;
    localparam logic [1:0] STEP_DEC2 = 2'h3;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 24'h000001;
    localparam logic [ADDR_W-1:0] ADDR_TWO = 24'h000002;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;
    localparam logic [LEN_W-1:0] LEN_ONE = 16'h0001;
    localparam logic [LEN_W-1:0] LEN_ZERO = 16'h0000;
    localparam logic [DATA_W-1:0] BYTE_MASK = 16'h00ff;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
    localparam logic [CH_N-1:0] ACK_ONE = 4'h1;
    localparam logic [CH_N-1:0] ACK_NONE = 4'h0;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ARB = 3'b001,
        S_PRIO = 3'b010,
        S_CYC = 3'b011,
        S_WR = 3'b100
    } state_t;
endpackage : dma_pkg

/* File: verif/bus_partner.sv */
`timescale 1ns/1ps
module bus_partner
    import dma_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Controller side
    input wire logic bus_req_i,
    input wire logic [ADDR_W-1:0] bus_addr_i,
    input wire logic bus_rd_i,
    input wire logic bus_wr_i,
    input wire logic slow_i,
    // Answers
    output logic bus_gnt_o,
    output logic bus_rdy_o,
    output logic [DATA_W-1:0] bus_rdata_o
);
    logic [1:0] wait_cnt;
    logic [1:0] next_wait_cnt;
    logic next_gnt;
    logic [DATA_W-1:0] word;
    always_comb begin
        next_gnt = bus_req_i;
        next_wait_cnt = ((bus_rd_i || bus_wr_i) && !bus_rdy_o) ? wait_cnt + 2'h1 : 2'h0;
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_gnt_o <= 1'b0;
            wait_cnt <= 2'h0;
        end else begin
            bus_gnt_o <= next_gnt;
            wait_cnt <= next_wait_cnt;
        end
    end
    // Slow memory answers in the third cycle
    assign bus_rdy_o = (bus_rd_i || bus_wr_i) && (!slow_i || wait_cnt == 2'h2);
    // Released data lines show the inverse word
    assign word = bus_addr_i[DATA_W-1:0] ^ 16'ha5c3;
    assign bus_rdata_o = bus_rd_i ? word : ~word;
endmodule : bus_partner

/* File: verif/dma_monitor.sv */
`timescale 1ns/1ps
module dma_monitor
    import dma_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Watched inputs
    input wire logic [CH_N-1:0] chan_enable_i,
    input wire logic [CH_N-1:0] continuous_i,
    input wire logic [CH_N-1:0] tc_int_en_i,
    input wire logic [CH_N-1:0] ovr_int_en_i,
    input wire logic [CH_N-1:0] periph_req_i,
    input wire logic [CH_N-1:0] sw_req_i,
    input wire logic bus_rdy_i,
    // Watched outputs
    input wire logic bus_req_o,
    input wire logic [ADDR_W-1:0] bus_addr_o,
    input wire logic bus_rd_o,
    input wire logic bus_wr_o,
    input wire logic [CH_N-1:0] ack_o,
    input wire logic [CH_N-1:0] tc_o,
    input wire logic [CH_N-1:0] ovr_o,
    input wire logic [CH_N-1:0] active_o,
    input wire logic [CH_N-1:0] irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_QUIET_AFTER_RESET: assert property (
        $fell(rst_i) |-> !bus_req_o && ack_o == 4'h0 && irq_o == 4'h0)
        else $error("outputs busy after reset");
    AST_CYCLE_OWNS_BUS: assert property (
        (bus_rd_o || bus_wr_o) |-> bus_req_o)
        else $error("bus cycle without bus request");
    AST_ACK_IN_CYCLE: assert property (
        ack_o != 4'h0 |-> $onehot(ack_o) && (bus_rd_o || bus_wr_o))
        else $error("acknowledge outside a bus cycle");
    AST_CYCLE_HOLD: assert property (
        (bus_rd_o || bus_wr_o) && !bus_rdy_i |=> $stable({bus_rd_o, bus_wr_o, bus_addr_o, ack_o}))
        else $error("bus cycle changed before ready");
    AST_IRQ_FOLLOWS: assert property (
        irq_o == ((tc_o & $past(tc_int_en_i)) | (ovr_o & $past(ovr_int_en_i))))
        else $error("interrupt does not follow flags");
    AST_TERMINAL_FLAGS: assert property (
        (tc_o & ~$past(tc_o)) != 4'h0 |-> ((tc_o & ~$past(tc_o)) & (active_o | ~ovr_o)) == 4'h0)
        else $error("terminal count without overrun or with active");
    AST_INTERMITTENT_RELEASE: assert property (
        (ack_o & ~continuous_i) != 4'h0 && bus_rdy_i |=> !bus_req_o)
        else $error("bus kept after intermittent item");
    AST_CONTINUOUS_KEEPS: assert property (
        (ack_o & continuous_i & (periph_req_i | sw_req_i) & chan_enable_i) != 4'h0 && bus_rdy_i
        |=> bus_req_o || (tc_o & ~$past(tc_o)) != 4'h0)
        else $error("bus dropped in continuous block");
    AST_REQ_RAISED: assert property (
        !bus_req_o && ((periph_req_i | sw_req_i) & chan_enable_i & active_o) != 4'h0 |=> bus_req_o)
        else $error("pending request not passed to bus");
endmodule : dma_monitor

bind transfer_controller dma_monitor mon_u (
    .clk_i(clk_i), .rst_i(rst_i), .chan_enable_i(chan_enable_i), .continuous_i(continuous_i),
    .tc_int_en_i(tc_int_en_i), .ovr_int_en_i(ovr_int_en_i), .periph_req_i(periph_req_i),
    .sw_req_i(sw_req_i), .bus_rdy_i(bus_rdy_i), .bus_req_o(bus_req_o), .bus_addr_o(bus_addr_o),
    .bus_rd_o(bus_rd_o), .bus_wr_o(bus_wr_o), .ack_o(ack_o), .tc_o(tc_o), .ovr_o(ovr_o),
    .active_o(active_o), .irq_o(irq_o)
);

/* File: verif/test_transfer_controller.sv */
`timescale 1ns/1ps
module test_transfer_controller;
    import dma_pkg::*;
    typedef struct {
        logic rd, wr, sz;
        logic [ADDR_W-1:0] addr;
        logic [CH_N-1:0] ack;
        logic [DATA_W-1:0] wd;
        int t;
    } rec_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic slow = 1'b0;
    logic [CH_N-1:0] chan_enable_i = 4'h0, dir_i = 4'h0, indirect_i = 4'h0, continuous_i = 4'h0;
    logic [CH_N-1:0] size16_i = 4'h0, a_adjust_i = 4'h0, b_adjust_i = 4'h0, load_i = 4'h0;
    logic [CH_N-1:0] tc_clear_i = 4'h0, ovr_clear_i = 4'h0, periph_req_i = 4'h0, sw_req_i = 4'h0;
    logic [CH_N-1:0] tc_int_en_i = 4'h3, ovr_int_en_i = 4'h4;
    logic [CH_N-1:0][1:0] a_step_i = 8'h00, b_step_i = 8'h00;
    logic [ADDR_W-1:0] load_addr_a_i = 24'h0, load_addr_b_i = 24'h0, bus_addr_o;
    logic [LEN_W-1:0] load_len_i = 16'h0;
    logic bus_gnt_i, bus_rdy_i, bus_req_o, bus_rd_o, bus_wr_o, bus_size16_o;
    logic [DATA_W-1:0] bus_rdata_i, bus_wdata_o;
    logic [CH_N-1:0] ack_o, tc_o, ovr_o, active_o, irq_o;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    rec_t log_q[$];

    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if ((bus_rd_o || bus_wr_o) && bus_rdy_i) begin
            log_q.push_back('{bus_rd_o, bus_wr_o, bus_size16_o, bus_addr_o, ack_o, bus_wdata_o, cyc});
        end
    end

    bus_partner far_u (
        .clk_i(clk_i), .rst_i(rst_i), .bus_req_i(bus_req_o), .bus_addr_i(bus_addr_o),
        .bus_rd_i(bus_rd_o), .bus_wr_i(bus_wr_o), .slow_i(slow),
        .bus_gnt_o(bus_gnt_i), .bus_rdy_o(bus_rdy_i), .bus_rdata_o(bus_rdata_i)
    );
    transfer_controller dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .chan_enable_i(chan_enable_i), .dir_i(dir_i),
        .indirect_i(indirect_i), .continuous_i(continuous_i), .size16_i(size16_i),
        .a_step_i(a_step_i), .b_step_i(b_step_i), .a_adjust_i(a_adjust_i),
        .b_adjust_i(b_adjust_i), .tc_int_en_i(tc_int_en_i), .ovr_int_en_i(ovr_int_en_i),
        .load_i(load_i), .load_addr_a_i(load_addr_a_i), .load_addr_b_i(load_addr_b_i),
        .load_len_i(load_len_i), .tc_clear_i(tc_clear_i), .ovr_clear_i(ovr_clear_i),
        .periph_req_i(periph_req_i), .sw_req_i(sw_req_i), .bus_gnt_i(bus_gnt_i),
        .bus_rdy_i(bus_rdy_i), .bus_rdata_i(bus_rdata_i), .bus_req_o(bus_req_o),
        .bus_addr_o(bus_addr_o), .bus_rd_o(bus_rd_o), .bus_wr_o(bus_wr_o),
        .bus_size16_o(bus_size16_o), .bus_wdata_o(bus_wdata_o), .ack_o(ack_o), .tc_o(tc_o),
        .ovr_o(ovr_o), .active_o(active_o), .irq_o(irq_o)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic check(input logic [ADDR_W-1:0] seen, input logic [ADDR_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [DATA_W-1:0] dat(input logic [ADDR_W-1:0] x);
        return x[DATA_W-1:0] ^ 16'ha5c3;
    endfunction : dat
    function automatic logic [ADDR_W-1:0] stp(input logic [1:0] c);
        return c[0] ? (c[1] ? 24'hfffffe : 24'h000002) : (c[1] ? 24'hffffff : 24'h000001);
    endfunction : stp
    task automatic setup(input int ch, input logic ind, cont, dr, sz, input logic [1:0] as, bs,
                         input logic adb, input logic [LEN_W-1:0] len);
        indirect_i[ch] = ind;
        continuous_i[ch] = cont;
        dir_i[ch] = dr;
        size16_i[ch] = sz;
        a_step_i[ch] = as;
        b_step_i[ch] = bs;
        a_adjust_i[ch] = 1'b1;
        b_adjust_i[ch] = adb;
        load_addr_a_i = {20'h00a10, 4'(ch)};
        load_addr_b_i = {20'h0b020, 4'(ch)};
        load_len_i = len;
        load_i[ch] = 1'b1;
        tick(1);
        load_i[ch] = 1'b0;
        chan_enable_i[ch] = 1'b1;
        tick(1);
    endtask : setup
    task automatic run_block(input int ch, input logic ind, cont, dr, sz, input logic [1:0] as,
                             bs, input logic adb, input logic [LEN_W-1:0] len, input int gap);
        logic [ADDR_W-1:0] a, b;
        rec_t r;
        int last;
        a = {20'h00a10, 4'(ch)};
        b = {20'h0b020, 4'(ch)};
        last = 0;
        log_q.delete();
        setup(ch, ind, cont, dr, sz, as, bs, adb, len);
        periph_req_i[ch] = 1'b1;
        for (int n = 0; n < 500 && !tc_o[ch]; n++) begin
            tick(1);
        end
        periph_req_i[ch] = 1'b0;
        chan_enable_i[ch] = 1'b0;
        tick(2);
        check(tc_o[ch] & ovr_o[ch] & ~active_o[ch], 1'b1);
        check(irq_o[ch], ch != 3);
        check(log_q.size(), ind ? 2 * len : len);
        for (int k = 0; k < len && log_q.size() > int'(ind); k++) begin
            r = log_q.pop_front();
            if (ind) begin
                check(r.rd, 1'b1);
                check(r.addr, dr ? b : a);
                r = log_q.pop_front();
                check(r.addr, dr ? a : b);
                check(r.wd, dat(dr ? b : a) & (sz ? 16'hffff : 16'h00ff));
            end else begin
                check(r.addr, a);
            end
            check(r.wr, ind | dr);
            check(r.ack, 4'h1 << ch);
            check(r.sz, sz);
            if (k > 0) check(r.t - last >= gap, 1'b1);
            last = r.t;
            a = a + stp(as);
            if (adb) b = b + stp(bs);
        end
        tc_clear_i[ch] = 1'b1;
        ovr_clear_i[ch] = 1'b1;
        tick(1);
        tc_clear_i[ch] = 1'b0;
        ovr_clear_i[ch] = 1'b0;
        tick(1);
        check(irq_o[ch] | tc_o[ch], 1'b0);
    endtask : run_block
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        give_verdict();
    end
    initial begin
        tick(4);
        rst_i = 1'b0;
        tick(1);
        check({bus_req_o, ack_o, irq_o, active_o}, 13'h0);
        periph_req_i[1] = 1'b1;
        tick(10);
        check(bus_req_o, 1'b0);
        periph_req_i[1] = 1'b0;
        run_block(0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0, 16'h0003, 3);
        run_block(1, 1'b0, 1'b1, 1'b1, 1'b1, 2'h3, 2'h0, 1'b0, 16'h0003, 1);
        run_block(2, 1'b1, 1'b0, 1'b0, 1'b1, 2'h1, 2'h2, 1'b1, 16'h0002, 5);
        slow = 1'b1;
        run_block(3, 1'b1, 1'b1, 1'b1, 1'b0, 2'h2, 2'h1, 1'b0, 16'h0003, 2);
        setup(3, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0, 16'h0001);
        setup(0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0, 16'h0001);
        log_q.delete();
        sw_req_i[3] = 1'b1;
        periph_req_i[0] = 1'b1;
        tick(60);
        check(log_q.size(), 2);
        check(log_q[0].ack, 4'h1);
        check(log_q[1].ack, 4'h8);
        give_verdict();
    end
endmodule : test_transfer_controller
